/* ldr_pkg.sv */
`default_nettype none
package ldr_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h36;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] OFS_ID = 8'h00;
    localparam logic [7:0] OFS_SOFT_RESET_BIT = 8'h01;
    localparam logic [7:0] OFS_ENABLE = 8'h10;
    localparam logic [7:0] OFS_BRT_CTL = 8'h11;
    localparam logic [7:0] OFS_PWM = 8'h12;
    localparam logic [7:0] OFS_BOOST = 8'h13;
    localparam logic [7:0] OFS_AF_HIGH = 8'h15;
    localparam logic [7:0] OFS_AF_LOW = 8'h16;
    localparam logic [7:0] OFS_FLASH = 8'h17;
    localparam logic [7:0] OFS_BRT_LOW = 8'h18;
    localparam logic [7:0] OFS_BRT_HIGH = 8'h19;
    localparam logic [7:0] OFS_FAULT_CTL = 8'h1e;
    localparam logic [7:0] OFS_FAULT_FLAGS = 8'h1f;
    localparam logic [7:0] ENABLE_RST = 8'h0e;
    localparam logic [7:0] BRT_CTL_RST = 8'h30;
    localparam logic [7:0] PWM_RST = 8'h73;
    localparam logic [7:0] BOOST_RST = 8'h6f;
    localparam logic [7:0] AF_RST = 8'h00;
    localparam logic [7:0] FLASH_RST = 8'h58;
    localparam logic [7:0] BRT_LOW_RST = 8'h07;
    localparam logic [7:0] BRT_HIGH_RST = 8'hff;
    localparam logic [7:0] FAULT_CTL_RST = 8'h40;
    localparam logic [5:0] FAULT_FLAGS_RST = 6'h00;
    localparam logic [7:0] ENABLE_MASK = 8'h0f;
    localparam logic [7:0] BOOST_MASK = 8'h7f;
    localparam logic [7:0] BRT_LOW_MASK = 8'h07;
    localparam int DEV_EN_BIT = 0;
    localparam int STR_EN_LSB = 1;
    localparam int SOFT_RESET_BIT_BIT = 0;
    localparam int MAP_BIT = 7;
    localparam int MODE_LSB = 4;
    localparam int RAMP_EN_BIT = 3;
    localparam int STEP_LSB = 0;
    localparam int FLASH_EN_BIT = 0;
    localparam int FLASH_CUR_LSB = 1;
    localparam int FLASH_TIME_LSB = 4;
    localparam logic [2:0] MODE_MAX = 3'h4;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_INDEX = 9'h008,
        ST_INDEX_ACK = 9'h010,
        ST_WRITE = 9'h020,
        ST_WRITE_ACK = 9'h040,
        ST_READ = 9'h080,
        ST_READ_ACK = 9'h100
    } ldr_state_t;
endpackage
`default_nettype wire

/* ldr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ldr_top #(
    parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h3 // arbitrary value
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe_n,
    input wire logic [5:0] i_fault_event,
    input wire logic i_flash_timeout,
    output logic o_device_enable,
    output logic [2:0] o_string_enable,
    output logic o_current_mapping_select,
    output logic [2:0] o_brightness_source_mode,
    output logic o_ramp_enable,
    output logic [2:0] o_ramp_step_time,
    output logic [7:0] o_pwm_control,
    output logic [6:0] o_boost_control,
    output logic [7:0] o_auto_freq_upper_level,
    output logic [7:0] o_auto_freq_lower_level,
    output logic [3:0] o_flash_time,
    output logic [2:0] o_flash_current,
    output logic o_flash_enable,
    output logic [10:0] o_brightness_code,
    output logic [7:0] o_fault_control,
    output logic [5:0] o_fault_flags
);
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_q;
    logic sda_q;
    logic [5:0] flt_s1_q;
    logic [5:0] flt_s2_q;
    logic tmo_s1_q;
    logic tmo_s2_q;
    ldr_pkg::ldr_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q;
    logic [7:0] idx_q;
    logic drive_q;
    logic ack_q;
    logic [7:0] en_q;
    logic [7:0] brt_ctl_q;
    logic [7:0] pwm_q;
    logic [7:0] boost_q;
    logic [7:0] af_hi_q;
    logic [7:0] af_lo_q;
    logic [7:0] flash_q;
    logic [7:0] brt_lo_q;
    logic [7:0] brt_hi_q;
    logic [7:0] fctl_q;
    logic [5:0] flags_q;
    logic [7:0] rd_data;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic wr_en;
    logic rd_load;
    logic soft_rst;
    logic unlocked;

    // pin synchronisers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            flt_s1_q <= 6'h00;
            flt_s2_q <= 6'h00;
            tmo_s1_q <= 1'b0;
            tmo_s2_q <= 1'b0;
        end else begin
            flt_s1_q <= i_fault_event;
            flt_s2_q <= flt_s1_q;
            tmo_s1_q <= i_flash_timeout;
            tmo_s2_q <= tmo_s1_q;
        end
    end

    assign scl_rise = scl_sync_q[1] & ~scl_q;
    assign scl_fall = ~scl_sync_q[1] & scl_q;
    assign start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
    assign stop_det = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];
    assign byte_done = scl_fall & (cnt_q == ldr_pkg::BITS_PER_BYTE);
    assign wr_en = (st_q == ldr_pkg::ST_WRITE) & byte_done;
    assign rd_load = scl_fall & (((st_q == ldr_pkg::ST_ADDR_ACK) & sr_q[0]) | ((st_q == ldr_pkg::ST_READ_ACK) & ack_q));
    assign soft_rst = wr_en & (idx_q == ldr_pkg::OFS_SOFT_RESET_BIT) & sr_q[ldr_pkg::SOFT_RESET_BIT_BIT];
    assign unlocked = ~en_q[ldr_pkg::DEV_EN_BIT] | (en_q[ldr_pkg::STR_EN_LSB +: 3] == 3'h0);
    assign o_sda_o = 1'b0;
    assign o_sda_oe_n = ~drive_q;

    // serial target sequencer
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ldr_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            idx_q <= 8'h00;
            drive_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (start_det) begin
            st_q <= ldr_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            drive_q <= 1'b0;
        end else if (stop_det) begin
            st_q <= ldr_pkg::ST_IDLE;
            drive_q <= 1'b0;
        end else begin
            unique case (st_q)
                ldr_pkg::ST_IDLE: begin
                    cnt_q <= 4'h0;
                end
                ldr_pkg::ST_ADDR, ldr_pkg::ST_INDEX, ldr_pkg::ST_WRITE: begin
                    if (scl_rise) begin
                        sr_q <= {sr_q[6:0], sda_sync_q[1]};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        cnt_q <= 4'h0;
                        if (st_q == ldr_pkg::ST_ADDR) begin
                            if (sr_q[7:1] == ldr_pkg::TARGET_ADDR) begin
                                st_q <= ldr_pkg::ST_ADDR_ACK;
                                drive_q <= 1'b1;
                            end else begin
                                st_q <= ldr_pkg::ST_IDLE;
                            end
                        end else if (st_q == ldr_pkg::ST_INDEX) begin
                            idx_q <= sr_q;
                            st_q <= ldr_pkg::ST_INDEX_ACK;
                            drive_q <= 1'b1;
                        end else begin
                            idx_q <= idx_q + 8'h01;
                            st_q <= ldr_pkg::ST_WRITE_ACK;
                            drive_q <= 1'b1;
                        end
                    end
                end
                ldr_pkg::ST_ADDR_ACK: begin
                    if (rd_load) begin
                        st_q <= ldr_pkg::ST_READ;
                        sr_q <= rd_data;
                        drive_q <= ~rd_data[7];
                    end else if (scl_fall) begin
                        st_q <= ldr_pkg::ST_INDEX;
                        drive_q <= 1'b0;
                    end
                end
                ldr_pkg::ST_INDEX_ACK, ldr_pkg::ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        st_q <= ldr_pkg::ST_WRITE;
                        drive_q <= 1'b0;
                    end
                end
                ldr_pkg::ST_READ: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        cnt_q <= 4'h0;
                        idx_q <= idx_q + 8'h01;
                        st_q <= ldr_pkg::ST_READ_ACK;
                        drive_q <= 1'b0;
                    end else if (scl_fall) begin
                        sr_q <= {sr_q[6:0], 1'b0};
                        drive_q <= ~sr_q[6];
                    end
                end
                ldr_pkg::ST_READ_ACK: begin
                    if (scl_rise) begin
                        ack_q <= ~sda_sync_q[1];
                    end else if (rd_load) begin
                        st_q <= ldr_pkg::ST_READ;
                        sr_q <= rd_data;
                        drive_q <= ~rd_data[7];
                    end else if (scl_fall) begin
                        st_q <= ldr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ldr_pkg::ST_IDLE;
                    drive_q <= 1'b0;
                end
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            en_q <= ldr_pkg::ENABLE_RST;
            brt_ctl_q <= ldr_pkg::BRT_CTL_RST;
            pwm_q <= ldr_pkg::PWM_RST;
            boost_q <= ldr_pkg::BOOST_RST;
            af_hi_q <= ldr_pkg::AF_RST;
            af_lo_q <= ldr_pkg::AF_RST;
            brt_lo_q <= ldr_pkg::BRT_LOW_RST;
            brt_hi_q <= ldr_pkg::BRT_HIGH_RST;
            fctl_q <= ldr_pkg::FAULT_CTL_RST;
        end else if (soft_rst) begin
            en_q <= ldr_pkg::ENABLE_RST;
            brt_ctl_q <= ldr_pkg::BRT_CTL_RST;
            pwm_q <= ldr_pkg::PWM_RST;
            boost_q <= ldr_pkg::BOOST_RST;
            af_hi_q <= ldr_pkg::AF_RST;
            af_lo_q <= ldr_pkg::AF_RST;
            brt_lo_q <= ldr_pkg::BRT_LOW_RST;
            brt_hi_q <= ldr_pkg::BRT_HIGH_RST;
            fctl_q <= ldr_pkg::FAULT_CTL_RST;
        end else if (wr_en) begin
            unique case (idx_q)
                ldr_pkg::OFS_ENABLE: en_q <= sr_q & ldr_pkg::ENABLE_MASK;
                ldr_pkg::OFS_BRT_CTL: begin
                    if (unlocked) begin
                        brt_ctl_q[7] <= sr_q[ldr_pkg::MAP_BIT];
                        brt_ctl_q[3:0] <= sr_q[3:0];
                        if (sr_q[ldr_pkg::MODE_LSB +: 3] <= ldr_pkg::MODE_MAX) begin
                            brt_ctl_q[6:4] <= sr_q[ldr_pkg::MODE_LSB +: 3];
                        end
                    end
                end
                ldr_pkg::OFS_PWM: if (unlocked) pwm_q <= sr_q;
                ldr_pkg::OFS_BOOST: boost_q <= sr_q & ldr_pkg::BOOST_MASK;
                ldr_pkg::OFS_AF_HIGH: if (unlocked) af_hi_q <= sr_q;
                ldr_pkg::OFS_AF_LOW: if (unlocked) af_lo_q <= sr_q;
                ldr_pkg::OFS_BRT_LOW: brt_lo_q <= sr_q & ldr_pkg::BRT_LOW_MASK;
                ldr_pkg::OFS_BRT_HIGH: brt_hi_q <= sr_q;
                ldr_pkg::OFS_FAULT_CTL: fctl_q <= sr_q;
                default: ;
            endcase
        end
    end

    // flash enable with hardware clear
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            flash_q <= ldr_pkg::FLASH_RST;
        end else if (soft_rst) begin
            flash_q <= ldr_pkg::FLASH_RST;
        end else begin
            if (wr_en && idx_q == ldr_pkg::OFS_FLASH) begin
                flash_q <= sr_q;
            end
            if (tmo_s2_q || (flt_s2_q != 6'h00)) begin
                flash_q[ldr_pkg::FLASH_EN_BIT] <= 1'b0;
            end
        end
    end

    // sticky fault flags, cleared by reading them
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            flags_q <= ldr_pkg::FAULT_FLAGS_RST;
        end else if (soft_rst) begin
            flags_q <= ldr_pkg::FAULT_FLAGS_RST;
        end else if (rd_load && idx_q == ldr_pkg::OFS_FAULT_FLAGS) begin
            flags_q <= flt_s2_q;
        end else begin
            flags_q <= flags_q | flt_s2_q;
        end
    end

    // read selection
    always_comb begin
        unique case (idx_q)
            ldr_pkg::OFS_ID: rd_data = {PART_CODE, REVISION_CODE};
            ldr_pkg::OFS_ENABLE: rd_data = en_q;
            ldr_pkg::OFS_BRT_CTL: rd_data = brt_ctl_q;
            ldr_pkg::OFS_PWM: rd_data = pwm_q;
            ldr_pkg::OFS_BOOST: rd_data = boost_q;
            ldr_pkg::OFS_AF_HIGH: rd_data = af_hi_q;
            ldr_pkg::OFS_AF_LOW: rd_data = af_lo_q;
            ldr_pkg::OFS_FLASH: rd_data = flash_q;
            ldr_pkg::OFS_BRT_LOW: rd_data = brt_lo_q;
            ldr_pkg::OFS_BRT_HIGH: rd_data = brt_hi_q;
            ldr_pkg::OFS_FAULT_CTL: rd_data = fctl_q;
            ldr_pkg::OFS_FAULT_FLAGS: rd_data = {2'h0, flags_q};
            default: rd_data = 8'h00;
        endcase
    end

    assign o_device_enable = en_q[ldr_pkg::DEV_EN_BIT];
    assign o_string_enable = en_q[ldr_pkg::STR_EN_LSB +: 3];
    assign o_current_mapping_select = brt_ctl_q[ldr_pkg::MAP_BIT];
    assign o_brightness_source_mode = brt_ctl_q[ldr_pkg::MODE_LSB +: 3];
    assign o_ramp_enable = brt_ctl_q[ldr_pkg::RAMP_EN_BIT];
    assign o_ramp_step_time = brt_ctl_q[ldr_pkg::STEP_LSB +: 3];
    assign o_pwm_control = pwm_q;
    assign o_boost_control = boost_q[6:0];
    assign o_auto_freq_upper_level = af_hi_q;
    assign o_auto_freq_lower_level = af_lo_q;
    assign o_flash_time = flash_q[ldr_pkg::FLASH_TIME_LSB +: 4];
    assign o_flash_current = flash_q[ldr_pkg::FLASH_CUR_LSB +: 3];
    assign o_flash_enable = flash_q[ldr_pkg::FLASH_EN_BIT];
    assign o_brightness_code = {brt_hi_q, brt_lo_q[2:0]};
    assign o_fault_control = fctl_q;
    assign o_fault_flags = flags_q;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_addr_ack;
        (st_q == ldr_pkg::ST_ADDR) && byte_done && (sr_q[7:1] == ldr_pkg::TARGET_ADDR)
            |=> (st_q == ldr_pkg::ST_ADDR_ACK) && !o_sda_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
    property p_addr_ignore;
        (st_q == ldr_pkg::ST_ADDR) && byte_done && (sr_q[7:1] != ldr_pkg::TARGET_ADDR)
            |=> (st_q == ldr_pkg::ST_IDLE) && o_sda_oe_n;
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address answered");
    property p_index_take;
        (st_q == ldr_pkg::ST_INDEX) && byte_done |=> idx_q == $past(sr_q);
    endproperty
    a_index_take: assert property (p_index_take) else $error("index byte not taken");
    property p_read_drive;
        rd_load |=> (o_sda_oe_n == $past(rd_data[7])) && (sr_q == $past(rd_data));
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not loaded");
    property p_guard;
        wr_en && !unlocked && !soft_rst |=> $stable(brt_ctl_q) && $stable(pwm_q) && $stable(af_hi_q)
            && $stable(af_lo_q);
    endproperty
    a_guard: assert property (p_guard) else $error("guarded field changed while enabled");
    property p_open_write;
        wr_en && unlocked && (idx_q == ldr_pkg::OFS_AF_LOW) |=> af_lo_q == $past(sr_q);
    endproperty
    a_open_write: assert property (p_open_write) else $error("unguarded write lost");
    property p_soft_reset;
        soft_rst |=> (en_q == ldr_pkg::ENABLE_RST) && (brt_hi_q == ldr_pkg::BRT_HIGH_RST)
            && (flash_q == ldr_pkg::FLASH_RST) && (flags_q == ldr_pkg::FAULT_FLAGS_RST);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
    property p_flash_clear;
        tmo_s2_q || (flt_s2_q != 6'h00) |=> !o_flash_enable;
    endproperty
    a_flash_clear: assert property (p_flash_clear) else $error("flash enable not cleared");
    property p_flag_set;
        flt_s2_q[0] && !soft_rst |=> flags_q[0] ##1 (flags_q[0] || $past(rd_load) || $past(soft_rst));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("fault flag lost");
    property p_mode_legal;
        o_brightness_source_mode <= ldr_pkg::MODE_MAX;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("reserved brightness mode held");
    property p_id_read;
        (idx_q == ldr_pkg::OFS_ID) |-> rd_data == {PART_CODE, REVISION_CODE};
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity register altered");
    property p_unmapped;
        (idx_q > ldr_pkg::OFS_FAULT_FLAGS) |-> rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped index reads nonzero");

    c_addr_ack: cover property ((st_q == ldr_pkg::ST_ADDR_ACK) && !o_sda_oe_n);
    c_write: cover property (wr_en && unlocked && (idx_q == ldr_pkg::OFS_BRT_CTL));
    c_soft_reset: cover property (soft_rst);
    c_read_more: cover property ((st_q == ldr_pkg::ST_READ_ACK) && rd_load);
endmodule
`default_nettype wire

/* ldr_i2c_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module ldr_i2c_ctl (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    // serial clock stands high and data released between frames
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // one bit, data set in low phase, sampled in high phase
    task automatic bit_io(input logic b, output logic s);
        #30 o_sda_pull = ~b;
        #20 o_scl = 1'b1;
        #20 s = i_sda;
        #10 o_scl = 1'b0;
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        #30 o_sda_pull = 1'b0;
        #20 o_scl = 1'b1;
        #20 o_sda_pull = 1'b1;
        #30 o_scl = 1'b0;
    endtask
    task automatic stop();
        #30 o_sda_pull = 1'b1;
        #20 o_scl = 1'b1;
        #20 o_sda_pull = 1'b0;
        #40;
    endtask
    // msb first, ninth bit left to the target
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~more, s);
    endtask
endmodule
`default_nettype wire

/* ldr_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ldr_top_bench;
    localparam logic [3:0] PART = 4'h9; // arbitrary value
    localparam logic [3:0] REV = 4'h6; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] fault = 6'h00;
    logic flash_to = 1'b0;
    logic scl, pull, sda_o, sda_oe_n, dev_en, map, ramp, flash_enable, a;
    logic [2:0] str_en, mode, step, exp_mode;
    logic [10:0] code;
    logic [5:0] flags;
    logic [7:0] pwm, af_hi, af_lo, fctl;
    logic [6:0] boost;
    logic [3:0] fl_t;
    logic [2:0] fl_c;
    wire logic sda;
    int n_fail = 0;
    int checks_done = 0;
    logic [7:0] ofs [14] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
        8'h1e, 8'h1f};
    logic [7:0] dfl [14] = '{{PART, REV}, 8'h00, 8'h0e, 8'h30, 8'h73, 8'h6f, 8'h00, 8'h00, 8'h00, 8'h58, 8'h07,
        8'hff, 8'h40, 8'h00};
    logic [7:0] grd [4] = '{8'h11, 8'h12, 8'h15, 8'h16};
    // wired-and data line with pull-up
    assign sda = ~(pull | ~sda_oe_n);
    always #5 clk = ~clk;
    ldr_i2c_ctl i_ldr_i2c_ctl (.i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
    ldr_top #(.PART_CODE(PART), .REVISION_CODE(REV)) i_ldr_top (
        .i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
        .i_fault_event(fault), .i_flash_timeout(flash_to), .o_device_enable(dev_en), .o_string_enable(str_en),
        .o_current_mapping_select(map), .o_brightness_source_mode(mode), .o_ramp_enable(ramp),
        .o_ramp_step_time(step), .o_pwm_control(pwm), .o_boost_control(boost), .o_auto_freq_upper_level(af_hi),
        .o_auto_freq_lower_level(af_lo), .o_flash_time(fl_t), .o_flash_current(fl_c), .o_flash_enable(flash_enable),
        .o_brightness_code(code), .o_fault_control(fctl), .o_fault_flags(flags));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic k;
        @(negedge clk);
        i_ldr_i2c_ctl.start();
        i_ldr_i2c_ctl.send(8'h6c, k);
        chk("write address ack", {10'h000, k}, 11'h001);
        i_ldr_i2c_ctl.send(idx, k);
        i_ldr_i2c_ctl.send(d, k);
        chk("data ack", {10'h000, k}, 11'h001);
        i_ldr_i2c_ctl.stop();
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic k;
        logic [7:0] d;
        @(negedge clk);
        i_ldr_i2c_ctl.start();
        i_ldr_i2c_ctl.send(8'h6c, k);
        i_ldr_i2c_ctl.send(idx, k);
        i_ldr_i2c_ctl.start();
        i_ldr_i2c_ctl.send(8'h6d, k);
        chk("read address ack", {10'h000, k}, 11'h001);
        i_ldr_i2c_ctl.recv(1'b0, d);
        i_ldr_i2c_ctl.stop();
        chk($sformatf("register %h", idx), {3'h0, d}, {3'h0, exp});
    endtask
    task automatic defaults(input string name);
        for (int k = 0; k < 14; k++) begin
            rc(ofs[k], dfl[k]);
        end
        chk("brightness code", code, 11'h7ff);
        chk("pwm control", {3'h0, pwm}, 11'h073);
        chk("boost control", {4'h0, boost}, 11'h06f);
        chk("auto freq upper", {3'h0, af_hi}, 11'h000);
        chk("auto freq lower", {3'h0, af_lo}, 11'h000);
        chk("flash fields", {4'h0, fl_t, fl_c}, 11'h02c);
        chk("fault control", {3'h0, fctl}, 11'h040);
        chk("data pin value", {10'h000, sda_o}, 11'h000);
        $display("test %s done", name);
    endtask
    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        defaults("reset values");
        @(negedge clk);
        i_ldr_i2c_ctl.start();
        i_ldr_i2c_ctl.send(8'h6e, a);
        chk("foreign address ack", {10'h000, a}, 11'h000);
        i_ldr_i2c_ctl.stop();
        wr(8'h00, 8'hff);
        wr(8'h14, 8'hff);
        wr(8'h01, 8'hfe);
        rc(8'h00, {PART, REV});
        rc(8'h14, 8'h00);
        rc(8'h01, 8'h00);
        $display("test address and fixed places done");
        wr(8'h10, 8'hff);
        chk("enables", {7'h00, str_en, dev_en}, 11'h00f);
        for (int k = 0; k < 4; k++) begin
            wr(grd[k], 8'h2a);
            rc(grd[k], dfl[k + 3 + 2 * (k > 1)]);
        end
        wr(8'h10, 8'h01);
        chk("enables", {7'h00, str_en, dev_en}, 11'h001);
        for (int k = 0; k < 4; k++) begin
            wr(grd[k], 8'h2a);
            rc(grd[k], 8'h2a);
        end
        chk("pwm output", {3'h0, pwm}, 11'h02a);
        chk("auto freq outputs", {3'h0, af_hi ^ af_lo}, 11'h000);
        $display("test write guard done");
        exp_mode = 3'h2;
        for (int i = 0; i < 8; i++) begin
            wr(8'h11, {i[0], i[2:0], i[0], i[2:0]});
            if (i <= 4) begin
                exp_mode = i[2:0];
            end
            chk("mode", {8'h00, mode}, {8'h00, exp_mode});
            chk("step", {8'h00, step}, 11'(i));
            chk("map ramp", {9'h000, map, ramp}, {9'h000, i[0], i[0]});
        end
        $display("test brightness modes done");
        wr(8'h18, 8'hfa);
        wr(8'h19, 8'h5a);
        rc(8'h18, 8'h02);
        chk("brightness code", code, {8'h5a, 3'h2});
        wr(8'h1e, 8'haa);
        rc(8'h1e, 8'haa);
        fault = 6'h21;
        repeat (6) @(negedge clk);
        fault = 6'h00;
        chk("flags", {5'h00, flags}, 11'h021);
        rc(8'h1f, 8'h21);
        rc(8'h1f, 8'h00);
        $display("test data and faults done");
        wr(8'h17, 8'h59);
        chk("flash on", {10'h000, flash_enable}, 11'h001);
        flash_to = 1'b1;
        repeat (6) @(negedge clk);
        flash_to = 1'b0;
        rc(8'h17, 8'h58);
        wr(8'h17, 8'h59);
        fault = 6'h01;
        repeat (6) @(negedge clk);
        fault = 6'h00;
        chk("flash off", {10'h000, flash_enable}, 11'h000);
        $display("test flash done");
        wr(8'h01, 8'h01);
        defaults("soft reset");
        end_of_test();
    end
endmodule
`default_nettype wire
